//--- include/pps_pkg.sv
// Purpose: constants and types for the printer port signal map
// Assumes: AHB-Lite register bus, 32-bit data
// Notes:   registers take one aligned word each
package pps_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PPS_STATUS_OFF  = 8'h00;
  localparam logic [7:0] PPS_CONTROL_OFF = 8'h04;
  localparam logic [7:0] PPS_DRIVE_OFF   = 8'h08;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PPS_ST_FAULT   = 3;
  localparam int PPS_ST_ONLINE  = 4;
  localparam int PPS_ST_PAPER   = 5;
  localparam int PPS_ST_TOOK    = 6;
  localparam int PPS_ST_NBUSY   = 7;
  localparam int PPS_CT_LATCH   = 0;
  localparam int PPS_CT_ALF     = 1;
  localparam int PPS_CT_INIT    = 2;
  localparam int PPS_CT_CHOOSE  = 3;
  localparam int PPS_DR_OD_ALF   = 0;
  localparam int PPS_DR_OD_LATCH = 1;

  // ----------------------------------------------------------------
  // reset values and bus codes
  // ----------------------------------------------------------------
  localparam logic [3:0] PPS_CONTROL_RST = 4'h0;
  localparam logic [1:0] PPS_DRIVE_RST   = 2'h0;
  localparam logic [1:0] PPS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PPS_HTRANS_SEQ    = 2'h3;
  localparam logic       PPS_HRESP_OKAY    = 1'b0;
  localparam int         PPS_SYNC_STAGES   = 2;

  // printer status inputs as a group
  typedef struct packed {
    logic busy;
    logic took_n;
    logic paper;
    logic online;
    logic fault_n;
  } pps_status_t;

  // one driven pin: level, output enable
  typedef struct packed {
    logic out;
    logic oe;
  } pps_pin_t;

endpackage

//--- design/pps_sync.sv
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: inputs are asynchronous to hclk
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module pps_sync #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // pps_sync

//--- design/pps_pin_drv.sv
// Purpose: push-pull or open-drain drive of one active-low output
// Assumes: od selects open-drain; external pull-up in that mode
// Notes:   output enable is high while the pin is driven
`timescale 1ns/100ps
module pps_pin_drv (
  // control
  input  wire logic level,
  input  wire logic od,
  // pin
  output pps_pkg::pps_pin_t pin
);
  // open drain drives only the low level
  assign pin = '{out: level, oe: (od ? ~level : 1'b1)};
endmodule // pps_pin_drv

//--- design/pps_top.sv
// Purpose: printer port status/control signal map behind AHB-Lite
// Assumes: printer pins asynchronous, hclk 25 MHz
// Notes:   status reads show synchronised pin levels, with busy inverted
`timescale 1ns/100ps

module pps_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // printer status inputs
  input  wire logic        printer_online_in,
  input  wire logic        paper_empty_in,
  input  wire logic        printer_busy_in,
  input  wire logic        printer_took_data_n,
  input  wire logic        printer_fault_in_n,
  // printer control outputs
  output logic             auto_linefeed_n,
  output logic             auto_linefeed_oe,
  output logic             data_latch_pulse_n,
  output logic             data_latch_pulse_oe,
  output logic             printer_initialise_n,
  output logic             printer_choose_out_n
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pps_pkg::pps_status_t raw_st;
  pps_pkg::pps_status_t st;
  logic [4:0]           st_q;

  assign raw_st = '{busy: printer_busy_in, took_n: printer_took_data_n,
                    paper: paper_empty_in, online: printer_online_in,
                    fault_n: printer_fault_in_n};

  pps_sync #(.W(5)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (raw_st),
    .q       (st_q)
  );
  assign st = st_q;

  // ----------------------------------------------------------------
  // bus address phase capture
  // ----------------------------------------------------------------
  logic       wr_pend_reg;
  logic       rd_pend_reg;
  logic [7:0] addr_reg;
  logic       take;
  logic       take_wr;
  logic       take_rd;

  assign take    = hsel && hready && (htrans == pps_pkg::PPS_HTRANS_NONSEQ ||
                                      htrans == pps_pkg::PPS_HTRANS_SEQ);
  assign take_wr = take && hwrite;
  assign take_rd = take && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= take_wr;
      rd_pend_reg <= take_rd;
      if (take) begin
        addr_reg <= haddr;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = pps_pkg::PPS_HRESP_OKAY;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  logic [3:0] ctrl_reg;
  logic [3:0] ctrl_next;
  logic [1:0] drive_reg;
  logic [1:0] drive_next;
  logic       wr_ctrl;
  logic       wr_drive;

  assign wr_ctrl    = wr_pend_reg && hit(addr_reg, pps_pkg::PPS_CONTROL_OFF);
  assign wr_drive   = wr_pend_reg && hit(addr_reg, pps_pkg::PPS_DRIVE_OFF);
  assign ctrl_next  = wr_ctrl  ? hwdata[3:0] : ctrl_reg;
  assign drive_next = wr_drive ? hwdata[1:0] : drive_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg  <= pps_pkg::PPS_CONTROL_RST;
      drive_reg <= pps_pkg::PPS_DRIVE_RST;
    end else begin
      ctrl_reg  <= ctrl_next;
      drive_reg <= drive_next;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [31:0] hrdata_reg;

  assign status_word = {24'h000000,
                        ~st.busy,
                        st.took_n,
                        st.paper,
                        st.online,
                        st.fault_n,
                        3'h0};
  assign rd_word = hit(haddr, pps_pkg::PPS_STATUS_OFF)  ? status_word :
                   hit(haddr, pps_pkg::PPS_CONTROL_OFF) ? {28'h0000000, ctrl_next} :
                   hit(haddr, pps_pkg::PPS_DRIVE_OFF)   ? {30'h00000000, drive_next} :
                   32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (take_rd) begin
      hrdata_reg <= rd_word;
    end
  end
  assign hrdata = hrdata_reg;

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  pps_pkg::pps_pin_t alf_pin;
  pps_pkg::pps_pin_t latch_pin;

  pps_pin_drv u_alf (
    .level (~ctrl_reg[pps_pkg::PPS_CT_ALF]),
    .od    (drive_reg[pps_pkg::PPS_DR_OD_ALF]),
    .pin   (alf_pin)
  );
  pps_pin_drv u_latch (
    .level (~ctrl_reg[pps_pkg::PPS_CT_LATCH]),
    .od    (drive_reg[pps_pkg::PPS_DR_OD_LATCH]),
    .pin   (latch_pin)
  );

  assign auto_linefeed_n      = alf_pin.out;
  assign auto_linefeed_oe     = alf_pin.oe;
  assign data_latch_pulse_n   = latch_pin.out;
  assign data_latch_pulse_oe  = latch_pin.oe;
  assign printer_initialise_n = ctrl_reg[pps_pkg::PPS_CT_INIT];
  assign printer_choose_out_n = ~ctrl_reg[pps_pkg::PPS_CT_CHOOSE];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence write_ctrl_s;
    take_wr && hit(haddr, pps_pkg::PPS_CONTROL_OFF);
  endsequence

  online_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take_rd && hit(haddr, pps_pkg::PPS_STATUS_OFF) |=> hrdata[4] == $past(st_q[1]))
    else $error("online bit wrong");
  paper_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take_rd && hit(haddr, pps_pkg::PPS_STATUS_OFF) |=> hrdata[5] == $past(st_q[2]))
    else $error("paper bit wrong");
  busy_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take_rd && hit(haddr, pps_pkg::PPS_STATUS_OFF) |=> hrdata[7] != $past(st_q[4]))
    else $error("busy bit not inverted");
  took_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take_rd && hit(haddr, pps_pkg::PPS_STATUS_OFF) |=> hrdata[6] == $past(st_q[3]))
    else $error("ack bit wrong");
  fault_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take_rd && hit(haddr, pps_pkg::PPS_STATUS_OFF) |=> hrdata[3] == $past(st_q[0]))
    else $error("fault bit wrong");
  linefeed_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    write_ctrl_s ##1 1'b1 |=> auto_linefeed_n == !$past(hwdata[1]))
    else $error("linefeed output wrong");
  latch_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    write_ctrl_s ##1 1'b1 |=> data_latch_pulse_n == !$past(hwdata[0]))
    else $error("latch output wrong");
  latch_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(data_latch_pulse_n) |-> $past(wr_ctrl))
    else $error("latch pulse without write");
  open_drain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    drive_reg[pps_pkg::PPS_DR_OD_LATCH] && data_latch_pulse_n |-> !data_latch_pulse_oe)
    else $error("open drain drives high");
  init_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    write_ctrl_s ##1 1'b1 |=> printer_initialise_n == $past(hwdata[2]))
    else $error("init output wrong");
  choose_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    write_ctrl_s ##1 1'b1 |=> printer_choose_out_n == !$past(hwdata[3]))
    else $error("select output wrong");
  reset_ctrl_a: assert property (@(posedge hclk)
    $rose(hresetn) |-> ctrl_reg == pps_pkg::PPS_CONTROL_RST &&
      drive_reg == pps_pkg::PPS_DRIVE_RST && !printer_initialise_n &&
      auto_linefeed_n && data_latch_pulse_n && printer_choose_out_n)
    else $error("control not cleared");

  // ----------------------------------------------------------------
  // assertions: register and read paths
  // ----------------------------------------------------------------
  sequence ctrl_data_s;
    wr_ctrl;
  endsequence

  sequence drive_data_s;
    wr_drive;
  endsequence

  sequence read_status_s;
    take_rd && hit(haddr, pps_pkg::PPS_STATUS_OFF);
  endsequence

  sequence read_unmapped_s;
    take_rd && !hit(haddr, pps_pkg::PPS_STATUS_OFF) &&
      !hit(haddr, pps_pkg::PPS_CONTROL_OFF) && !hit(haddr, pps_pkg::PPS_DRIVE_OFF);
  endsequence

  ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_data_s |=> ctrl_reg == $past(hwdata[3:0]))
    else $error("control write lost");
  ctrl_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_ctrl |=> $stable(ctrl_reg))
    else $error("control changed without write");
  drive_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    drive_data_s |=> drive_reg == $past(hwdata[1:0]))
    else $error("drive write lost");
  drive_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_drive |=> $stable(drive_reg))
    else $error("drive changed without write");
  ctrl_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take_rd && hit(haddr, pps_pkg::PPS_CONTROL_OFF) && !wr_ctrl |=>
      hrdata[3:0] == $past(ctrl_reg) && hrdata[31:4] == 28'h0000000)
    else $error("control read wrong");
  drive_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take_rd && hit(haddr, pps_pkg::PPS_DRIVE_OFF) && !wr_drive |=>
      hrdata[1:0] == $past(drive_reg) && hrdata[31:2] == 30'h0)
    else $error("drive read wrong");
  status_spare_a: assert property (@(posedge hclk) disable iff (!hresetn)
    read_status_s |=> hrdata[2:0] == 3'h0 && hrdata[31:8] == 24'h000000)
    else $error("status spare bits set");
  unmapped_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    read_unmapped_s |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  read_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_reg |-> hrdata == $past(rd_word))
    else $error("read data not in data phase");
  read_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !take_rd |=> $stable(hrdata))
    else $error("read data changed without read");
  // both stages must hold post-reset samples before the delay is checked
  sync_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) && $past(hresetn, 2) |-> st_q == $past(raw_st, 2))
    else $error("status pins not two flops late");

  // ----------------------------------------------------------------
  // assertions: pin drive
  // ----------------------------------------------------------------
  // open drain leaves the high level to the external pull-up
  alf_drain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    drive_reg[pps_pkg::PPS_DR_OD_ALF] && auto_linefeed_n |-> !auto_linefeed_oe)
    else $error("linefeed open drain drives high");
  alf_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !drive_reg[pps_pkg::PPS_DR_OD_ALF] |-> auto_linefeed_oe)
    else $error("linefeed push-pull not driven");
  latch_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !drive_reg[pps_pkg::PPS_DR_OD_LATCH] |-> data_latch_pulse_oe)
    else $error("latch push-pull not driven");
  alf_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !auto_linefeed_n |-> auto_linefeed_oe)
    else $error("linefeed low level not driven");
  latch_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !data_latch_pulse_n |-> data_latch_pulse_oe)
    else $error("latch low level not driven");
  latch_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(data_latch_pulse_n) |-> $past(wr_ctrl))
    else $error("latch pulse ended without write");

endmodule // pps_top

//--- tb/pps_printer.sv
// Purpose: printer model for the port signal map bench
// Assumes: latch line already resolved with its pull-up
// Notes:   status levels come from the bench; a latch pulse drops took_n
`timescale 1ns/100ps
module pps_printer (
  // clock
  input  wire logic       hclk,
  // lines from the port
  input  wire logic       latch_line_n,
  // requested busy, took_n, paper, online, fault_n
  input  wire logic [4:0] req,
  // status lines
  output pps_pkg::pps_status_t st,
  output int              captures
);
  logic prev;
  int   took_cnt;

  initial begin
    captures = 0;
    took_cnt = 0;
    prev     = 1'b1;
  end

  // capture at the end of a low pulse, then acknowledge
  always @(posedge hclk) begin
    if (prev === 1'b0 && latch_line_n === 1'b1) begin
      captures <= captures + 1;
      took_cnt <= 4;
    end else if (took_cnt > 0) begin
      took_cnt <= took_cnt - 1;
    end
    prev <= latch_line_n;
  end

  assign st = {req[4], req[3] & (took_cnt == 0), req[2:0]};
endmodule // pps_printer

//--- tb/tb_printer_port_signal_map.sv
// Purpose: self-checking bench for the printer port signal map
// Assumes: zero-wait slave, two-flop status inputs
// Notes:   random values from an 8-bit lfsr seeded with 33
`timescale 1ns/100ps
module tb_printer_port_signal_map;
  logic        hclk, hresetn, hsel, hwrite;
  logic [7:0]  haddr, lfsr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic        hreadyout, hresp, alf, alf_oe, dl, dl_oe, init_n, choose_n;
  logic [4:0]  req;
  logic [3:0]  c;
  logic [1:0]  d;
  int          fail_count, tests_run, captures, n0;
  pps_pkg::pps_status_t st;
  wire         latch_line_n = dl_oe ? dl : 1'b1;

  pps_top i_pps_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .printer_online_in(st.online), .paper_empty_in(st.paper), .printer_busy_in(st.busy),
    .printer_took_data_n(st.took_n), .printer_fault_in_n(st.fault_n),
    .auto_linefeed_n(alf), .auto_linefeed_oe(alf_oe), .data_latch_pulse_n(dl),
    .data_latch_pulse_oe(dl_oe), .printer_initialise_n(init_n),
    .printer_choose_out_n(choose_n));

  pps_printer i_pps_printer (.hclk(hclk), .latch_line_n(latch_line_n), .req(req),
    .st(st), .captures(captures));

  always #20 hclk = ~hclk;

  function logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= pps_pkg::PPS_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", hresp, pps_pkg::PPS_HRESP_OKAY);
  endtask

  task set_pins(input logic [3:0] cv, input logic [1:0] dv);
    bus(1'b1, pps_pkg::PPS_CONTROL_OFF, {28'h0, cv});
    bus(1'b1, pps_pkg::PPS_DRIVE_OFF, {30'h0, dv});
    @(negedge hclk);
    check("alf", alf, !cv[1]);
    check("latch", dl, !cv[0]);
    check("init", init_n, cv[2]);
    check("choose", choose_n, !cv[3]);
    check("alf_oe", alf_oe, !dv[0] | cv[1]);
    check("latch_oe", dl_oe, !dv[1] | cv[0]);
    @(posedge hclk);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 8'h00;
    htrans = 2'h0; hwdata = 32'h0; req = 5'h08; lfsr = 8'h21;
    fail_count = 0; tests_run = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("reset init", init_n, 1'b0);
    check("reset latch", dl, 1'b1);
    bus(1'b0, pps_pkg::PPS_CONTROL_OFF, 32'h0);
    check("reset control", rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      c = lfsr[3:0];
      d = lfsr[5:4];
      if (i == 0) c = 4'hF;
      set_pins(c, d);
      lfsr = lfsr_next(lfsr);
      req <= lfsr[4:0];
      // lets a strobe acknowledge run out and the pins pass both flops
      repeat (6) @(posedge hclk);
      bus(1'b0, pps_pkg::PPS_STATUS_OFF, 32'h0);
      check("status", rd, {24'h0, !req[4], req[3:0], 3'h0});
    end
    set_pins(4'hF, 2'h3);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check("midrun init", init_n, 1'b0);
    check("midrun latch", dl, 1'b1);
    check("midrun alf", alf, 1'b1);
    check("midrun choose", choose_n, 1'b1);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, pps_pkg::PPS_DRIVE_OFF, 32'h0);
    check("midrun drive", rd, 32'h0);
    req <= 5'h09;
    set_pins(4'h0, 2'h3);
    n0 = captures;
    set_pins(4'h1, 2'h3);
    set_pins(4'h0, 2'h3);
    repeat (2) @(posedge hclk);
    check("captures", captures, n0 + 1);
    bus(1'b0, pps_pkg::PPS_STATUS_OFF, 32'h0);
    check("took status", rd, 32'h88);
    bus(1'b1, 8'h0C, 32'hF);
    bus(1'b0, 8'h0C, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b0, pps_pkg::PPS_CONTROL_OFF, 32'h0);
    check("control kept", rd, 32'h0);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    test_done();
  end
endmodule // tb_printer_port_signal_map
